/* File: rtl/cswfm_map.vh */
// cswfm_map.vh: register map, field positions, reset values
// assumes: included by the clock switch top module, by bare name
//
// Behaviour
// - fast rc runs when active group 01
// - trim code shifts fast rc 1.5% steps
// - trim 0000 keeps calibrated centre frequency
// - slow rc enabled at power-on reset
// - after powerup timer slow rc on if needed
// - monitor enabled keeps slow rc except sleep
// - failure raises trap, switches to fast rc
// - failure loads fast rc, sets flag, clears request
// - watchdog unaffected by clock failure
// - no start before powerup timer means failure
// - switch only between groups, primary from config
// - active group field read-only, shows effect
// - resets load both group fields from config
// - request rises on start, clear aborts
// - clock fail flag read-only failure indicator
// - config 1x disables switching and monitor
// - switching disabled: config selects, field reports
// - low byte unlock 0x46 then 0x57
// - high byte unlock 0x78 then 0x9A
// - unlock opens one write only
// - lock status bit mirrors pll lock
// - groups 00 sec, 01 fast, 10 slow, 11 pri
// - lock bit at 5, pll clock held until lock
`ifndef CSWFM_MAP_VH
`define CSWFM_MAP_VH

// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define CSWFM_CTRL_OFS 4'h0
`define CSWFM_STAT_OFS 4'h4
`define CSWFM_BIT_REQ 0
`define CSWFM_BIT_FAIL 3
`define CSWFM_BIT_LOCK 5
`define CSWFM_REQ_GRP_LO 8
`define CSWFM_ACT_GRP_LO 12
`define CSWFM_TRIM_LO 16
`define CSWFM_GRP_SEC 2'h0
`define CSWFM_GRP_FAST 2'h1
`define CSWFM_GRP_SLOW 2'h2
`define CSWFM_GRP_PRI 2'h3
`define CSWFM_TRIM_RST 4'h0
`define CSWFM_KEY_LO1 8'h46
`define CSWFM_KEY_LO2 8'h57
`define CSWFM_KEY_HI1 8'h78
`define CSWFM_KEY_HI2 8'h9A
`endif

/* File: rtl/cswfm_sync.v */
// cswfm_sync.v: three flop input synchroniser with agreement filter
// assumes: input asynchronous to clk_sys_i
`timescale 1ns/1ps
module cswfm_sync (
   // clock and reset
   input wire clk_sys_i,
   input wire resetn_i,
   // data
   input wire async_i,
   output reg sync_o
);
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         s1_reg <= async_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            sync_o <= s3_reg;
         end
      end
   end
endmodule

/* File: rtl/cswfm_top.v */
// cswfm_top.v: clock source switch, slow rc enable and failure monitor
// assumes: wishbone classic slave, oscillator status arrives on pins
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "cswfm_map.vh"
module cswfm_top (
   // clock and reset
   input wire clk_sys_i,
   input wire resetn_i,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // configuration bits
   input wire [1:0] initial_group_config_i,
   input wire [3:0] primary_choice_config_i,
   input wire [1:0] switch_monitor_config_i,
   input wire primary_uses_pll_i,
   input wire soft_watchdog_enable_i,
   // reset and power state
   input wire supply_drop_reset_i,
   input wire powerup_timer_done_i,
   input wire sleep_i,
   // oscillator status pins
   input wire [3:0] group_ready_i,
   input wire osc_fail_i,
   input wire pll_lock_i,
   // clock selection outputs
   output reg [1:0] sys_clk_group_o,
   output reg [3:0] primary_choice_o,
   output reg [3:0] rc_trim_code_o,
   output reg slow_rc_enable_o,
   output reg clock_fail_trap_o,
   output reg clock_hold_o
);
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   wire [3:0] rdy_s;
   wire fail_s;
   wire lock_s;
   wire pup_s;
   wire sleep_s;
   wire drop_s;
   wire drop_raw;
   wire [8:0] sync_in;
   wire [8:0] sync_out;
   assign drop_raw = supply_drop_reset_i;
   assign sync_in = {drop_raw, sleep_i, powerup_timer_done_i,
                     pll_lock_i, osc_fail_i, group_ready_i};
   genvar gi;
   generate
      for (gi = 0; gi < 9; gi = gi + 1) begin : g_sync
         cswfm_sync u_sync (
            .clk_sys_i(clk_sys_i),
            .resetn_i(resetn_i),
            .async_i(sync_in[gi]),
            .sync_o(sync_out[gi])
         );
      end
   endgenerate
   assign rdy_s = sync_out[3:0];
   assign fail_s = sync_out[4];
   assign lock_s = sync_out[5];
   assign pup_s = sync_out[6];
   assign sleep_s = sync_out[7];
   assign drop_s = sync_out[8];

   // ----------------------------------------
   // state
   // ----------------------------------------
   localparam ST_INIT = 2'd0;
   localparam ST_RUN = 2'd1;
   localparam ST_SWITCH = 2'd2;
   reg [1:0] state_reg;
   reg [1:0] active_source_group_reg;
   reg [1:0] requested_source_group_reg;
   reg [3:0] rc_trim_code_reg;
   reg switch_request_reg;
   reg clock_fail_flag_reg;
   reg [1:0] unlock_lo_reg;
   reg [1:0] unlock_hi_reg;
   reg drop_d_reg;
   reg pup_d_reg;

   // monitor and switching enabled only when config is 0x
   wire switch_en;
   assign switch_en = ~switch_monitor_config_i[1];
   wire pri_pll;
   assign pri_pll = primary_uses_pll_i &&
                    active_source_group_reg == `CSWFM_GRP_PRI;
   // source not started or pll unlocked at powerup timer rise counts as failure
   wire not_started;
   assign not_started = ~rdy_s[active_source_group_reg] ||
                        (pri_pll && ~lock_s);
   wire pup_rise;
   assign pup_rise = pup_s && !pup_d_reg;
   wire fail_event;
   assign fail_event = switch_en && !sleep_s &&
                       active_source_group_reg != `CSWFM_GRP_FAST &&
                       (fail_s || (pup_rise && not_started));
   wire drop_rise;
   assign drop_rise = drop_s && !drop_d_reg;

   // ----------------------------------------
   // wishbone decode
   // ----------------------------------------
   wire wb_req;
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire ctrl_hit;
   assign ctrl_hit = wb_adr_i == `CSWFM_CTRL_OFS;
   wire wr_lo;
   wire wr_hi;
   assign wr_lo = wb_req && wb_we_i && ctrl_hit && wb_sel_i[0];
   assign wr_hi = wb_req && wb_we_i && ctrl_hit && wb_sel_i[1];
   wire wr_trim;
   assign wr_trim = wb_req && wb_we_i && ctrl_hit && wb_sel_i[2];
   wire any_wr;
   assign any_wr = wb_req && wb_we_i;
   wire [7:0] b0;
   wire [7:0] b1;
   assign b0 = wb_dat_i[7:0];
   assign b1 = wb_dat_i[15:8];
   wire lo_open;
   wire hi_open;
   assign lo_open = unlock_lo_reg == 2'd2;
   assign hi_open = unlock_hi_reg == 2'd2;

   wire [15:0] ctrl_word;
   assign ctrl_word = {2'b00, active_source_group_reg, 2'b00,
                       requested_source_group_reg, 2'b00,
                       lock_s, 1'b0, clock_fail_flag_reg,
                       2'b00, switch_request_reg};
   wire [31:0] ctrl_rd;
   assign ctrl_rd = {12'h000, rc_trim_code_reg, ctrl_word};
   wire [31:0] stat_rd;
   assign stat_rd = {26'h0000000, state_reg, slow_rc_enable_o,
                     switch_en, sleep_s, pup_s};

   // ----------------------------------------
   // bus slave and unlock sequences
   // ----------------------------------------
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         unlock_lo_reg <= 2'd0;
         unlock_hi_reg <= 2'd0;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req && !wb_we_i) begin
            if (ctrl_hit) begin
               wb_dat_o <= ctrl_rd;
            end else if (wb_adr_i == `CSWFM_STAT_OFS) begin
               wb_dat_o <= stat_rd;
            end else begin
               wb_dat_o <= 32'h00000000;
            end
         end
         if (any_wr) begin
            if (unlock_lo_reg == 2'd0 && wr_lo && b0 == `CSWFM_KEY_LO1) begin
               unlock_lo_reg <= 2'd1;
            end else if (unlock_lo_reg == 2'd1 && wr_lo &&
                         b0 == `CSWFM_KEY_LO2) begin
               unlock_lo_reg <= 2'd2;
            end else begin
               unlock_lo_reg <= 2'd0;
            end
            if (unlock_hi_reg == 2'd0 && wr_hi && b1 == `CSWFM_KEY_HI1) begin
               unlock_hi_reg <= 2'd1;
            end else if (unlock_hi_reg == 2'd1 && wr_hi &&
                         b1 == `CSWFM_KEY_HI2) begin
               unlock_hi_reg <= 2'd2;
            end else begin
               unlock_hi_reg <= 2'd0;
            end
         end else if (wb_req) begin
            unlock_lo_reg <= 2'd0;
            unlock_hi_reg <= 2'd0;
         end
      end
   end

   // ----------------------------------------
   // clock switch state machine
   // ----------------------------------------
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= ST_INIT;
         active_source_group_reg <= `CSWFM_GRP_FAST;
         requested_source_group_reg <= `CSWFM_GRP_FAST;
         rc_trim_code_reg <= `CSWFM_TRIM_RST;
         switch_request_reg <= 1'b0;
         clock_fail_flag_reg <= 1'b0;
         drop_d_reg <= 1'b0;
         pup_d_reg <= 1'b0;
      end else begin
         drop_d_reg <= drop_s;
         pup_d_reg <= pup_s;
         if (wr_trim) begin
            rc_trim_code_reg <= wb_dat_i[19:16];
         end
         if (state_reg == ST_INIT || drop_rise) begin
            active_source_group_reg <= initial_group_config_i;
            requested_source_group_reg <= initial_group_config_i;
            switch_request_reg <= 1'b0;
            state_reg <= ST_RUN;
         end else if (!switch_en) begin
            active_source_group_reg <= initial_group_config_i;
            switch_request_reg <= 1'b0;
            state_reg <= ST_RUN;
         end else if (fail_event) begin
            active_source_group_reg <= `CSWFM_GRP_FAST;
            clock_fail_flag_reg <= 1'b1;
            switch_request_reg <= 1'b0;
            state_reg <= ST_RUN;
         end else begin
            if (hi_open && wr_hi) begin
               requested_source_group_reg <= b1[1:0];
            end
            case (state_reg)
               ST_RUN: begin
                  if (lo_open && wr_lo && b0[`CSWFM_BIT_REQ]) begin
                     switch_request_reg <= 1'b1;
                     state_reg <= ST_SWITCH;
                  end
               end
               ST_SWITCH: begin
                  if (lo_open && wr_lo && !b0[`CSWFM_BIT_REQ]) begin
                     switch_request_reg <= 1'b0;
                     state_reg <= ST_RUN;
                  end else if (requested_source_group_reg ==
                               active_source_group_reg) begin
                     switch_request_reg <= 1'b0;
                     state_reg <= ST_RUN;
                  end else if (rdy_s[requested_source_group_reg]) begin
                     active_source_group_reg <=
                        requested_source_group_reg;
                     switch_request_reg <= 1'b0;
                     state_reg <= ST_RUN;
                  end
               end
               default: begin
                  state_reg <= ST_RUN;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sys_clk_group_o <= `CSWFM_GRP_FAST;
         primary_choice_o <= 4'h0;
         rc_trim_code_o <= `CSWFM_TRIM_RST;
         slow_rc_enable_o <= 1'b1;
         clock_fail_trap_o <= 1'b0;
         clock_hold_o <= 1'b1;
      end else begin
         sys_clk_group_o <= active_source_group_reg;
         primary_choice_o <= primary_choice_config_i;
         rc_trim_code_o <= rc_trim_code_reg;
         clock_fail_trap_o <= fail_event;
         clock_hold_o <= pri_pll && !lock_s;
         if (!pup_s) begin
            slow_rc_enable_o <= 1'b1;
         end else if (switch_en) begin
            slow_rc_enable_o <= !sleep_s;
         end else begin
            slow_rc_enable_o <= soft_watchdog_enable_i ||
               active_source_group_reg == `CSWFM_GRP_SLOW;
         end
      end
   end
endmodule

/* File: sim/cswfm_osc_model.sv */
// cswfm_osc_model.sv: oscillator sources behind the clock switch
// assumes: primary starts late after reset, internal rcs always run
`timescale 1ns/1ps
module cswfm_osc_model #(
   parameter START = 16
) (
   input wire clk_sys_i,
   input wire resetn_i,
   input wire pri_fail_i,
   output reg [3:0] group_ready_o,
   output reg osc_fail_o,
   output reg pll_lock_o
);
   reg [7:0] cnt_reg;
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_reg <= 8'h00;
         group_ready_o <= 4'h7;
         osc_fail_o <= 1'b0;
         pll_lock_o <= 1'b0;
      end else begin
         if (cnt_reg != 8'hFF)
            cnt_reg <= cnt_reg + 8'h01;
         group_ready_o[3] <= (cnt_reg >= START) && !pri_fail_i;
         osc_fail_o <= pri_fail_i;
         pll_lock_o <= (cnt_reg >= START + 8) && !pri_fail_i;
      end
   end
endmodule

/* File: sim/cswfm_props.sv */
// cswfm_props.sv: port assertions for the clock switch block
// assumes: bound onto cswfm_top, one clock domain
`timescale 1ns/1ps
module cswfm_props (
   input wire clk_sys_i,
   input wire resetn_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire [1:0] switch_monitor_config_i,
   input wire [1:0] initial_group_config_i,
   input wire [3:0] primary_choice_config_i,
   input wire primary_uses_pll_i,
   input wire pll_lock_i,
   input wire sleep_i,
   input wire [1:0] sys_clk_group_o,
   input wire [3:0] primary_choice_o,
   input wire slow_rc_enable_o,
   input wire clock_fail_trap_o,
   input wire clock_hold_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_off;
      (switch_monitor_config_i[1] && $stable(initial_group_config_i))[*8];
   endsequence
   sequence s_pll_wait;
      (sys_clk_group_o == 2'h3 && primary_uses_pll_i && !pll_lock_i)[*6];
   endsequence
   a_ack_after_take: assert property (s_take |=> wb_ack_o)
      else $error("no ack after request");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_trap_pulse: assert property (clock_fail_trap_o |=> !clock_fail_trap_o)
      else $error("trap longer than one cycle");
   a_trap_to_frc: assert property (clock_fail_trap_o |-> ##[0:2] sys_clk_group_o == 2'h1)
      else $error("no switch to fast rc after trap");
   a_off_no_trap: assert property (s_off |-> !clock_fail_trap_o)
      else $error("trap while monitor disabled");
   a_off_follows: assert property (s_off |-> sys_clk_group_o == initial_group_config_i)
      else $error("group does not follow config");
   a_mon_slow_on: assert property ((!switch_monitor_config_i[1] && !sleep_i)[*8] |-> slow_rc_enable_o)
      else $error("slow rc off with monitor on");
   a_pri_choice: assert property ($stable(primary_choice_config_i)[*6] |-> primary_choice_o == primary_choice_config_i)
      else $error("primary choice not from config");
   a_hold_pll: assert property (s_pll_wait |-> clock_hold_o)
      else $error("clock not held before lock");
   a_hold_free: assert property ((sys_clk_group_o == 2'h3 && pll_lock_i)[*6] |-> !clock_hold_o)
      else $error("clock held after lock");
endmodule
bind cswfm_top cswfm_props u_props (.clk_sys_i, .resetn_i, .wb_cyc_i,
   .wb_stb_i, .wb_ack_o, .switch_monitor_config_i, .initial_group_config_i,
   .primary_choice_config_i, .primary_uses_pll_i, .pll_lock_i, .sleep_i,
   .sys_clk_group_o, .primary_choice_o, .slow_rc_enable_o,
   .clock_fail_trap_o, .clock_hold_o);

/* File: sim/tb_top.sv */
// tb_top.sv: self-checking bench for the clock switch block
// assumes: cswfm_top and the oscillator model, 50 MHz clock
`timescale 1ns/1ps
module tb_top;
   reg clk_sys_i, resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, fail_cmd;
   reg [3:0] wb_adr_i, wb_sel_i, primary_choice_config_i, t;
   reg [31:0] wb_dat_i, rd;
   reg [1:0] initial_group_config_i, switch_monitor_config_i;
   reg powerup_timer_done_i, sleep_i, soft_watchdog_enable_i;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, clock_fail_trap_o, slow_rc_enable_o, clock_hold_o;
   wire osc_fail_i, pll_lock_i;
   wire [1:0] sys_clk_group_o;
   wire [3:0] primary_choice_o, rc_trim_code_o, group_ready_i;
   integer seed, n_mismatch, cmp_count, cyc_n, i, j;
   cswfm_top dut_u (.clk_sys_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .initial_group_config_i, .primary_choice_config_i,
      .switch_monitor_config_i, .primary_uses_pll_i(1'b1),
      .soft_watchdog_enable_i, .supply_drop_reset_i(1'b0),
      .powerup_timer_done_i, .sleep_i, .group_ready_i, .osc_fail_i,
      .pll_lock_i, .sys_clk_group_o, .primary_choice_o, .rc_trim_code_o,
      .slow_rc_enable_o, .clock_fail_trap_o, .clock_hold_o);
   cswfm_osc_model osc_u (.clk_sys_i, .resetn_i, .pri_fail_i(fail_cmd),
      .group_ready_o(group_ready_i), .osc_fail_o(osc_fail_i),
      .pll_lock_o(pll_lock_i));
   // ----
   // helpers
   // ----
   function [31:0] bl(input hi, input [7:0] v);
      bl = hi ? {16'h0, v, 8'h0} : {24'h0, v};
   endfunction
   function [31:0] ctl(input [1:0] a, input [1:0] n, input [3:0] tr);
      ctl = {12'h0, tr, 2'h0, a, 2'h0, n, 8'h0};
   endfunction
   task finish_test;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wb(input w, input [3:0] a, input [3:0] s, input [31:0] d);
      @(posedge clk_sys_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      @(posedge clk_sys_i);
      while (wb_ack_o !== 1'b1)
         @(posedge clk_sys_i);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task gw(input hi, input [7:0] v);
      wb(1'b1, 4'h0, {2'h0, hi, !hi}, bl(hi, hi ? 8'h78 : 8'h46));
      wb(1'b1, 4'h0, {2'h0, hi, !hi}, bl(hi, hi ? 8'h9A : 8'h57));
      wb(1'b1, 4'h0, {2'h0, hi, !hi}, bl(hi, v));
   endtask
   task rdc(input [1:0] a, input [1:0] n, input [3:0] tr);
      wb(1'b0, 4'h0, 4'hF, 32'h0);
      chk("ctrl", rd & 32'h000F_3300, ctl(a, n, tr));
   endtask
   task wgrp(input [1:0] g);
      i = 0;
      while (sys_clk_group_o !== g && i < 200) begin
         @(posedge clk_sys_i);
         i = i + 1;
      end
      chk("sys group", {30'h0, sys_clk_group_o}, {30'h0, g});
   endtask
   task do_reset;
      @(posedge clk_sys_i);
      resetn_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
   endtask
   // ----
   // clock, timeout, sequence
   // ----
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      cyc_n = cyc_n + 1;
      if (cyc_n == 20000) begin
         n_mismatch = n_mismatch + 1;
         finish_test;
      end
   end
   initial begin
      seed = 54893;
      {n_mismatch, cmp_count, cyc_n} = 0;
      {resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, fail_cmd} = 5'h0;
      {wb_adr_i, wb_sel_i, wb_dat_i, powerup_timer_done_i} = 0;
      {sleep_i, soft_watchdog_enable_i} = 2'h0;
      primary_choice_config_i = $random(seed);
      initial_group_config_i = 2'h1;
      switch_monitor_config_i = 2'h0;
      do_reset;
      chk("slow rc", {31'h0, slow_rc_enable_o}, 32'h1);
      rdc(2'h1, 2'h1, 4'h0);
      wb(1'b0, 4'h8, 4'hF, 32'h0);
      chk("unmapped", rd, 32'h0);
      powerup_timer_done_i <= 1'b1;
      repeat (10) @(posedge clk_sys_i);
      chk("slow rc", {31'h0, slow_rc_enable_o}, 32'h1);
      wb(1'b0, 4'h4, 4'hF, 32'h0);
      chk("status", rd, 32'h0000001D);
      sleep_i <= 1'b1;
      repeat (10) @(posedge clk_sys_i);
      chk("slow rc sleep", {31'h0, slow_rc_enable_o}, 32'h0);
      sleep_i <= 1'b0;
      repeat (10) @(posedge clk_sys_i);
      chk("slow rc wake", {31'h0, slow_rc_enable_o}, 32'h1);
      for (j = 0; j < 6; j = j + 1) begin
         t = (j == 0) ? 4'h8 : (j == 1) ? 4'h7 : (j == 5) ? 4'h0 : $random(seed);
         wb(1'b1, 4'h0, 4'h4, {12'h0, t, 16'h0});
         rdc(2'h1, 2'h1, t);
         chk("trim out", {28'h0, rc_trim_code_o}, {28'h0, t});
      end
      wb(1'b1, 4'h0, 4'h2, bl(1'b1, 8'h78));
      wb(1'b0, 4'h0, 4'hF, 32'h0);
      wb(1'b1, 4'h0, 4'h2, bl(1'b1, 8'h9A));
      wb(1'b1, 4'h0, 4'h2, bl(1'b1, 8'h00));
      rdc(2'h1, 2'h1, 4'h0);
      gw(1'b1, 8'h32);
      rdc(2'h1, 2'h2, 4'h0);
      wb(1'b1, 4'h0, 4'h2, bl(1'b1, 8'h03));
      rdc(2'h1, 2'h2, 4'h0);
      gw(1'b0, 8'h01);
      wgrp(2'h2);
      rdc(2'h2, 2'h2, 4'h0);
      chk("request", {31'h0, rd[0]}, 32'h0);
      gw(1'b1, 8'h03);
      gw(1'b0, 8'h01);
      wgrp(2'h3);
      chk("pri choice", {28'h0, primary_choice_o}, {28'h0, primary_choice_config_i});
      fail_cmd <= 1'b1;
      wgrp(2'h1);
      wb(1'b0, 4'h0, 4'hF, 32'h0);
      chk("fail ctrl", rd & 32'h3009, 32'h1008);
      fail_cmd <= 1'b0;
      initial_group_config_i <= 2'h3;
      powerup_timer_done_i <= 1'b0;
      do_reset;
      repeat (10) @(posedge clk_sys_i);
      powerup_timer_done_i <= 1'b1;
      wgrp(2'h1);
      wb(1'b0, 4'h0, 4'hF, 32'h0);
      chk("late start", rd & 32'h3009, 32'h1008);
      switch_monitor_config_i <= 2'h2;
      powerup_timer_done_i <= 1'b0;
      do_reset;
      powerup_timer_done_i <= 1'b1;
      repeat (30) @(posedge clk_sys_i);
      chk("slow rc", {31'h0, slow_rc_enable_o}, 32'h0);
      soft_watchdog_enable_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      chk("slow rc wdt", {31'h0, slow_rc_enable_o}, 32'h1);
      gw(1'b1, 8'h01);
      gw(1'b0, 8'h01);
      repeat (20) @(posedge clk_sys_i);
      wgrp(2'h3);
      finish_test;
   end
endmodule
